// *** inc/tctc_pkg.sv ***
/* constants of the tape channel task control block: codes, paging, sizes.
   assumes nothing; used by scoped names only. */
package tctc_pkg;
   localparam logic [15:0] TASK_SENSE = 16'h009C;
   localparam logic [15:0] TASK_CLEAR = 16'h009D;
   localparam logic [15:0] TASK_WRAP_BA = 16'h0098;
   localparam logic [15:0] TASK_WRAP_FA = 16'h0099;
   localparam logic [5:0] FC_SENSE_FIRST = 6'h36;
   localparam logic [5:0] FC_SENSE_LAST = 6'h3E;
   localparam logic [5:0] SENSE_TOTAL = 6'h28;
   localparam logic [5:0] SENSE_PAGE = 6'h0A;
   localparam logic [5:0] SENSE_LAST_PAGE = 6'h1E;
   localparam logic [5:0] SENSE_RESET_PTR = 6'h00;
   localparam logic [5:0] BA_MAX_WORDS = 6'h08;
   localparam logic [5:0] FA_WORDS = 6'h10;
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 32;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [5:0] IRQ_LEVEL_RESET = 6'h00;
   localparam logic [15:0] CTRL_INIT = 16'h0001;
   localparam logic [15:0] CTRL_STOP = 16'h0002;
   localparam logic [3:0] CLEAR_CYCLES = 4'h4;
endpackage

// *** logic/tctc_fifo.sv ***
/*
 * loop-back buffer: synchronous fifo with valid/ready on both sides.
 * assumes one clock, active-low async reset, and a clock enable.
 */
`timescale 1ns/1ps
module tctc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wptr_reg;
   logic [AW:0] rptr_reg;
   logic push;
   logic pop;
   // full when pointers differ only in the wrap bit
   assign in_ready_o = (wptr_reg - rptr_reg) != (AW+1)'(DEPTH);
   assign out_valid_o = (wptr_reg != rptr_reg);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem_reg[rptr_reg[AW-1:0]];
   // storage has no reset; only pointers define contents
   always_ff @(posedge clock_i) begin
      if (ce_i && push) begin
         mem_reg[wptr_reg[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
      end else if (ce_i) begin
         if (flush_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
         end else begin
            if (push) wptr_reg <= wptr_reg + 1'b1;
            if (pop) rptr_reg <= rptr_reg + 1'b1;
         end
      end
   end
endmodule

// *** logic/tctc_sense_mem.sv ***
/*
 * forty-byte drive sense store, written from the drive side, read as byte pairs.
 * assumes the caller keeps the pair index within range.
 */
`timescale 1ns/1ps
module tctc_sense_mem (
   input wire logic clock_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [5:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic [5:0] rd_addr_i,
   output logic [15:0] rd_data_o
);
   logic [7:0] mem_reg [40];
   always_ff @(posedge clock_i) begin
      if (ce_i && wr_en_i && (wr_addr_i < tctc_pkg::SENSE_TOTAL)) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
   end
   // registered read: byte x in high half, x plus one in low half
   always_ff @(posedge clock_i) begin
      if (ce_i) begin
         rd_data_o <= {mem_reg[rd_addr_i], mem_reg[6'(rd_addr_i + 6'h01)]};
      end
   end
endmodule

// *** logic/tctc_top.sv ***
/*
 * command interpreter of the tape channel controller: sense paging, device
 * clear, two loop-back tests, initialize and stop-io control words.
 * assumes decoded one-cycle request strobes, a memory port with a
 * handshake, and a formatter that reports reset completion.
 */
// Functional notes
// - sense task returns bytes in pairs on 36..3E
// - function 3X delivers bytes X and X+1
// - each further sense task advances ten bytes
// - at most forty sense bytes, ten per task
// - device clear ends readout, pointer to zero
// - device clear resets transport, busy until done
// - device clear moves no data, ends normally
// - loop-back direction from latest address channel lsb
// - bus-adapter write fetches one to eight words
// - loop-back read returns buffered words unchanged
// - zero range ends at once, no status
// - during loop-back ignore tasks for other channels
// - format-adapter write moves exactly sixteen words; the code moves the task range, capped at sixteen
// - control word always accepted, even busy
// - initialize returns all channels to power-up state
// - initialize aborts all, keeps nothing, no interrupt
// - initialize zeroes every interrupt level
// - stop-io aborts, interrupt as normal end
// - stop-io keeps status, address and range
// - first sense byte copied to status word 3
`timescale 1ns/1ps
module tctc_top (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic task_valid_i,
   input wire logic [15:0] task_code_i,
   input wire logic [9:0] task_chan_i,
   input wire logic [15:0] task_range_i,
   input wire logic addr_load_i,
   input wire logic [9:0] addr_chan_i,
   input wire logic [15:0] addr_value_i,
   input wire logic ctrl_valid_i,
   input wire logic [15:0] ctrl_word_i,
   input wire logic irq_level_load_i,
   input wire logic [5:0] irq_level_i,
   input wire logic in_valid_i,
   input wire logic [5:0] in_func_i,
   input wire logic sense_wr_i,
   input wire logic [5:0] sense_wr_addr_i,
   input wire logic [7:0] sense_wr_data_i,
   input wire logic fmt_reset_done_i,
   output logic mem_rd_req_o,
   output logic [15:0] mem_addr_o,
   input wire logic mem_rd_valid_i,
   input wire logic [15:0] mem_rd_data_i,
   output logic mem_wr_req_o,
   output logic [15:0] mem_wr_data_o,
   input wire logic mem_wr_ready_i,
   output logic task_ack_o,
   output logic task_nak_o,
   output logic in_valid_o,
   output logic [15:0] in_data_o,
   output logic busy_o,
   output logic fmt_reset_o,
   output logic done_o,
   output logic irq_o,
   output logic [5:0] irq_level_o,
   output logic [15:0] status_word3_o,
   output logic [15:0] range_o
);
   typedef enum logic [2:0] {
      TCTC_IDLE, TCTC_CLEAR, TCTC_FETCH, TCTC_STORE, TCTC_END
   } tctc_state_t;

   tctc_state_t state_reg;
   logic [5:0] sense_ptr_reg;
   logic sense_active_reg;
   logic dir_read_reg;
   logic [9:0] wrap_chan_reg;
   logic wrap_armed_reg;
   logic [15:0] mem_addr_reg;
   logic [15:0] range_reg;
   logic [3:0] clr_cnt_reg;
   logic in_pend_reg;
   logic [5:0] rd_addr;
   logic [15:0] sense_pair;
   logic ctrl_init;
   logic ctrl_stop;
   logic task_other_chan;
   logic task_take;
   logic is_sense_fc;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [15:0] fifo_out_data;
   logic fifo_flush;
   logic [5:0] bound_words;
   logic pwr_copy_reg;

   // control word decode; accepted in any state, busy or not
   assign ctrl_init = ctrl_valid_i && (ctrl_word_i == tctc_pkg::CTRL_INIT);
   assign ctrl_stop = ctrl_valid_i && (ctrl_word_i == tctc_pkg::CTRL_STOP);
   // while a loop-back is armed, tasks for another channel are dropped silently
   assign task_other_chan = (wrap_armed_reg || state_reg == TCTC_FETCH
                             || state_reg == TCTC_STORE) && (task_chan_i != wrap_chan_reg);
   assign task_take = task_valid_i && !task_other_chan && !ctrl_valid_i;
   assign is_sense_fc = in_valid_i && (in_func_i >= tctc_pkg::FC_SENSE_FIRST)
                        && (in_func_i <= tctc_pkg::FC_SENSE_LAST) && !in_func_i[0];
   // pair index: page base plus X offset, byte X high and X+1 low
   // idle reads sit on byte zero so the status copy always sees the first byte
   assign rd_addr = is_sense_fc ? 6'(sense_ptr_reg + (in_func_i - tctc_pkg::FC_SENSE_FIRST))
                    : tctc_pkg::SENSE_RESET_PTR;
   assign fifo_flush = ctrl_init || (ctrl_stop && state_reg != TCTC_IDLE);
   // bus-adapter test clamps at eight words; outside that is undefined anyway
   assign bound_words = (task_code_i == tctc_pkg::TASK_WRAP_FA) ? tctc_pkg::FA_WORDS
                        : tctc_pkg::BA_MAX_WORDS;

   tctc_sense_mem u_sense (
      .clock_i(clock_i),
      .ce_i(ce_i),
      .wr_en_i(sense_wr_i),
      .wr_addr_i(sense_wr_addr_i),
      .wr_data_i(sense_wr_data_i),
      .rd_addr_i(rd_addr),
      .rd_data_o(sense_pair)
   );

   tctc_fifo #(
      .WIDTH(tctc_pkg::FIFO_WIDTH),
      .DEPTH(tctc_pkg::FIFO_DEPTH),
      .AW(5)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .ce_i(ce_i),
      .flush_i(fifo_flush),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(mem_rd_data_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data)
   );

   // fifo fills from memory on a write test, drains to memory on a read test
   assign fifo_in_valid = (state_reg == TCTC_FETCH) && mem_rd_valid_i;
   assign fifo_out_ready = (state_reg == TCTC_STORE) && mem_wr_req_o && mem_wr_ready_i;

   // main sequencer
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= TCTC_IDLE;
      end else if (ce_i) begin
         if (ctrl_init) begin
            state_reg <= TCTC_IDLE;
         end else if (ctrl_stop && state_reg != TCTC_IDLE) begin
            state_reg <= TCTC_END;
         end else begin
            case (state_reg)
               TCTC_IDLE: begin
                  if (task_take && task_code_i == tctc_pkg::TASK_CLEAR) begin
                     state_reg <= TCTC_CLEAR;
                  end else if (task_take && (task_code_i == tctc_pkg::TASK_WRAP_BA
                               || task_code_i == tctc_pkg::TASK_WRAP_FA)
                               && task_range_i != tctc_pkg::WORD_RESET) begin
                     state_reg <= dir_read_reg ? TCTC_STORE : TCTC_FETCH;
                  end
               end
               TCTC_CLEAR: begin
                  if (clr_cnt_reg == 4'h0 && fmt_reset_done_i) state_reg <= TCTC_END;
               end
               TCTC_FETCH: begin
                  if (range_reg == tctc_pkg::WORD_RESET) state_reg <= TCTC_END;
               end
               TCTC_STORE: begin
                  if (range_reg == tctc_pkg::WORD_RESET || !fifo_out_valid) begin
                     state_reg <= TCTC_END;
                  end
               end
               TCTC_END: state_reg <= TCTC_IDLE;
               default: state_reg <= TCTC_IDLE;
            endcase
         end
      end
   end

   // range loaded by task, address by address load; both counted per word, kept on stop-io
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         range_reg <= tctc_pkg::WORD_RESET;
         mem_addr_reg <= tctc_pkg::WORD_RESET;
      end else if (ce_i) begin
         if (ctrl_init) begin
            range_reg <= tctc_pkg::WORD_RESET;
            mem_addr_reg <= tctc_pkg::WORD_RESET;
         end else if (ctrl_stop) begin
            range_reg <= range_reg;
         end else if (addr_load_i) begin
            mem_addr_reg <= addr_value_i;
         end else if (state_reg == TCTC_IDLE && task_take
                      && (task_code_i == tctc_pkg::TASK_WRAP_BA
                      || task_code_i == tctc_pkg::TASK_WRAP_FA)) begin
            // clamp keeps the buffer inside its bound for out-of-spec ranges
            range_reg <= (task_range_i > {10'h000, bound_words})
                         ? {10'h000, bound_words} : task_range_i;
         end else if (fifo_in_valid && fifo_in_ready) begin
            range_reg <= range_reg - 16'h0001;
            mem_addr_reg <= mem_addr_reg + 16'h0002;
         end else if (fifo_out_ready && fifo_out_valid) begin
            range_reg <= range_reg - 16'h0001;
            mem_addr_reg <= mem_addr_reg + 16'h0002;
         end
      end
   end

   // direction and loop-back ownership
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dir_read_reg <= 1'b0;
         wrap_chan_reg <= 10'h000;
         wrap_armed_reg <= 1'b0;
      end else if (ce_i) begin
         if (ctrl_init) begin
            dir_read_reg <= 1'b0;
            wrap_armed_reg <= 1'b0;
         end else begin
            if (addr_load_i) dir_read_reg <= addr_chan_i[0];
            if (state_reg == TCTC_IDLE && task_take && (task_code_i == tctc_pkg::TASK_WRAP_BA
                || task_code_i == tctc_pkg::TASK_WRAP_FA) && task_range_i != 16'h0000) begin
               wrap_chan_reg <= task_chan_i;
               wrap_armed_reg <= !dir_read_reg; // read completes the pair
            end
         end
      end
   end

   // device-clear hold-off counter
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clr_cnt_reg <= 4'h0;
      end else if (ce_i) begin
         if (state_reg == TCTC_IDLE) clr_cnt_reg <= tctc_pkg::CLEAR_CYCLES;
         else if (state_reg == TCTC_CLEAR && clr_cnt_reg != 4'h0) begin
            clr_cnt_reg <= clr_cnt_reg - 4'h1;
         end
      end
   end

   // sense page pointer; clear and initialize return it to byte zero
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sense_ptr_reg <= tctc_pkg::SENSE_RESET_PTR;
         sense_active_reg <= 1'b0;
      end else if (ce_i) begin
         if (ctrl_init || (task_take && task_code_i == tctc_pkg::TASK_CLEAR)) begin
            sense_ptr_reg <= tctc_pkg::SENSE_RESET_PTR;
            sense_active_reg <= 1'b0;
         end else if (task_take && task_code_i == tctc_pkg::TASK_SENSE) begin
            sense_active_reg <= 1'b1;
            if (sense_active_reg && sense_ptr_reg < tctc_pkg::SENSE_LAST_PAGE) begin
               sense_ptr_reg <= sense_ptr_reg + tctc_pkg::SENSE_PAGE;
            end // saturates at last ten-byte page
         end
      end
   end

   // input answer: two cycles after the request, data from the sense store
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         in_pend_reg <= 1'b0;
         in_valid_o <= 1'b0;
         in_data_o <= tctc_pkg::WORD_RESET;
      end else if (ce_i) begin
         in_pend_reg <= is_sense_fc;
         in_valid_o <= in_pend_reg;
         if (in_pend_reg) in_data_o <= sense_active_reg ? sense_pair : 16'h0000;
      end
   end

   // status word 3 takes the first sense byte after power-up or initialize and at each task end with no sense readout active
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_word3_o <= tctc_pkg::WORD_RESET;
         pwr_copy_reg <= 1'b1;
      end else if (ce_i) begin
         pwr_copy_reg <= ctrl_init;
         if (pwr_copy_reg || (state_reg == TCTC_END && !ctrl_stop && !sense_active_reg)) begin
            status_word3_o <= {8'h00, sense_pair[15:8]};
         end
      end
   end

   // handshake and status outputs
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         task_ack_o <= 1'b0;
         task_nak_o <= 1'b0;
         busy_o <= 1'b0;
         fmt_reset_o <= 1'b0;
         done_o <= 1'b0;
         irq_o <= 1'b0;
         irq_level_o <= tctc_pkg::IRQ_LEVEL_RESET;
         mem_rd_req_o <= 1'b0;
         mem_wr_req_o <= 1'b0;
         mem_addr_o <= tctc_pkg::WORD_RESET;
         mem_wr_data_o <= tctc_pkg::WORD_RESET;
         range_o <= tctc_pkg::WORD_RESET;
      end else if (ce_i) begin
         task_ack_o <= task_take && (state_reg == TCTC_IDLE || task_code_i == tctc_pkg::TASK_CLEAR);
         task_nak_o <= task_take && state_reg != TCTC_IDLE && task_code_i != tctc_pkg::TASK_CLEAR;
         busy_o <= !ctrl_init && state_reg != TCTC_IDLE && state_reg != TCTC_END;
         fmt_reset_o <= !ctrl_init && state_reg == TCTC_CLEAR;
         // zero range never reaches TCTC_END, so no status or interrupt
         done_o <= !ctrl_init && state_reg == TCTC_END;
         irq_o <= !ctrl_init && state_reg == TCTC_END && irq_level_o != 6'h00;
         if (ctrl_init) irq_level_o <= tctc_pkg::IRQ_LEVEL_RESET;
         else if (irq_level_load_i) irq_level_o <= irq_level_i;
         // request drops a cycle after each word so the address can step first
         mem_rd_req_o <= !fifo_flush && state_reg == TCTC_FETCH && fifo_in_ready
                         && range_reg != tctc_pkg::WORD_RESET && !fifo_in_valid;
         mem_wr_req_o <= !fifo_flush && state_reg == TCTC_STORE && fifo_out_valid
                         && !fifo_out_ready;
         mem_addr_o <= mem_addr_reg;
         mem_wr_data_o <= fifo_out_data;
         range_o <= range_reg;
      end
   end
endmodule

// *** verif/tctc_mem_model.sv ***
/* memory model on the far side of the loop-back data path.
   assumes one clock; slow_i adds wait cycles before each answer. */
`timescale 1ns/1ps
module tctc_mem_model (
   input wire logic clock_i,
   input wire logic slow_i,
   input wire logic rd_req_i,
   input wire logic wr_req_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wr_data_i,
   output logic rd_valid_o,
   output logic [15:0] rd_data_o,
   output logic wr_ready_o
);
   logic [15:0] wlog [logic [15:0]];
   int rd_cnt = 0;
   int wait_cnt = 0;
   // address-tied pattern exposes replayed words
   function automatic logic [15:0] pat(input logic [15:0] a);
      return {a[7:0] ^ 8'hC3, a[15:8] ^ 8'h5A};
   endfunction
   initial begin
      {rd_valid_o, wr_ready_o, rd_data_o} = {2'b00, 16'hFFFF};
   end
   // one answer per request
   always @(posedge clock_i) begin
      rd_valid_o <= 1'b0;
      wr_ready_o <= 1'b0;
      rd_data_o <= ~rd_data_o; // released data bus shows no stale word
      if ((rd_req_i || wr_req_i) && !rd_valid_o && !wr_ready_o) begin
         if (wait_cnt < (slow_i ? 6 : 0)) begin
            wait_cnt <= wait_cnt + 1;
         end else if (rd_req_i) begin
            wait_cnt <= 0;
            rd_valid_o <= 1'b1;
            rd_data_o <= pat(addr_i);
            rd_cnt <= rd_cnt + 1;
         end else begin
            wait_cnt <= 0;
            wr_ready_o <= 1'b1;
            wlog[addr_i] = wr_data_i; // design holds word until ready is seen
         end
      end
   end
endmodule

// *** verif/tctc_props.sv ***
/* checker for tctc_top: task answers, device clear, controls, sense replies.
   assumes it is bound to tctc_top and sees only that module's ports. */
`timescale 1ns/1ps
module tctc_props (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic task_valid_i,
   input wire logic [15:0] task_code_i,
   input wire logic [15:0] task_range_i,
   input wire logic ctrl_valid_i,
   input wire logic [15:0] ctrl_word_i,
   input wire logic in_valid_i,
   input wire logic [5:0] in_func_i,
   input wire logic fmt_reset_done_i,
   input wire logic mem_rd_req_o,
   input wire logic mem_wr_req_o,
   input wire logic task_ack_o,
   input wire logic task_nak_o,
   input wire logic in_valid_o,
   input wire logic busy_o,
   input wire logic fmt_reset_o,
   input wire logic done_o,
   input wire logic irq_o,
   input wire logic [5:0] irq_level_o,
   input wire logic [15:0] range_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   logic task_go;
   logic init_go;
   logic stop_go;
   // a control word in the same cycle wins over a task
   assign task_go = task_valid_i && ce_i && !ctrl_valid_i;
   assign init_go = ctrl_valid_i && ce_i && ctrl_word_i == tctc_pkg::CTRL_INIT;
   assign stop_go = ctrl_valid_i && ce_i && ctrl_word_i == tctc_pkg::CTRL_STOP;
   sequence s_clear_taken;
      task_go && task_code_i == tctc_pkg::TASK_CLEAR ##1 task_ack_o;
   endsequence
   sequence s_zero_taken;
      task_go && task_range_i == 16'h0000 && (task_code_i == tctc_pkg::TASK_WRAP_BA ||
         task_code_i == tctc_pkg::TASK_WRAP_FA) ##1 task_ack_o;
   endsequence
   a_answer_follows: assert property (
      (task_ack_o || task_nak_o) |-> $past(task_go) && !(task_ack_o && task_nak_o))
      else $error("task answer without a taken task");
   a_clear_drives_reset: assert property (s_clear_taken |=> fmt_reset_o [*4])
      else $error("clear did not hold formatter reset");
   a_clear_quiet: assert property (
      fmt_reset_o |-> busy_o && !mem_rd_req_o && !mem_wr_req_o)
      else $error("clear moved data or dropped busy");
   a_clear_waits_done: assert property (
      $fell(fmt_reset_o) |-> $past(fmt_reset_done_i) || $past(ctrl_valid_i))
      else $error("formatter reset left before completion");
   a_clear_ends_done: assert property (
      $fell(fmt_reset_o) && !$past(ctrl_valid_i) |-> ##[0:1] done_o)
      else $error("clear did not end normally");
   a_zero_range_idle: assert property (
      s_zero_taken |-> !busy_o ##1 (!busy_o && !done_o) [*4])
      else $error("zero range loop-back ran");
   a_init_resets: assert property (
      init_go |-> ##2 (!busy_o && !fmt_reset_o && !mem_rd_req_o && !mem_wr_req_o &&
         irq_level_o == tctc_pkg::IRQ_LEVEL_RESET && range_o == tctc_pkg::WORD_RESET))
      else $error("initialize left state behind");
   a_init_silent: assert property (init_go |=> (!irq_o && !done_o) [*4])
      else $error("initialize raised an ending");
   a_stop_interrupts: assert property (
      stop_go && busy_o && irq_level_o != 6'h00 |-> ##[1:4] (done_o && irq_o))
      else $error("stop did not interrupt");
   a_stop_keeps_range: assert property (
      stop_go && busy_o |=> range_o == $past(range_o))
      else $error("stop changed the range");
   a_irq_needs_level: assert property (irq_o |-> irq_level_o != 6'h00)
      else $error("interrupt at level zero");
   a_sense_answers: assert property (
      in_valid_i && ce_i && in_func_i inside {6'h36, 6'h38, 6'h3A, 6'h3C, 6'h3E}
      |-> ##2 in_valid_o)
      else $error("sense input got no reply");
endmodule
bind tctc_top tctc_props props_u (.*);

// *** verif/testbench.sv ***
/* self-checking bench for tctc_top with a memory model on the data side.
   assumes the design package and the memory model are compiled first. */
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   logic clock_i, rst_b_i, ce_i, task_valid_i, addr_load_i, ctrl_valid_i, irq_level_load_i;
   logic in_valid_i, sense_wr_i, fmt_reset_done_i, mem_rd_valid_i, mem_wr_ready_i, slow_i;
   logic [15:0] task_code_i, task_range_i, addr_value_i, ctrl_word_i, mem_rd_data_i;
   logic [9:0] task_chan_i, addr_chan_i;
   logic [5:0] irq_level_i, in_func_i, sense_wr_addr_i, irq_level_o;
   logic [7:0] sense_wr_data_i;
   logic mem_rd_req_o, mem_wr_req_o, task_ack_o, task_nak_o, in_valid_o, busy_o;
   logic fmt_reset_o, done_o, irq_o;
   logic [15:0] mem_addr_o, mem_wr_data_o, in_data_o, status_word3_o, range_o;
   int errors = 0;
   int comparisons = 0;
   tctc_top dut_u (.*);
   tctc_mem_model mem_u (.clock_i(clock_i), .slow_i(slow_i), .rd_req_i(mem_rd_req_o),
      .wr_req_i(mem_wr_req_o), .addr_i(mem_addr_o), .wr_data_i(mem_wr_data_o),
      .rd_valid_o(mem_rd_valid_i), .rd_data_o(mem_rd_data_i), .wr_ready_o(mem_wr_ready_i));
   // free-running 100 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   function automatic logic [7:0] sb(input int i);
      return 8'h40 + 8'(i);
   endfunction
   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // bounded wait: 0 done, 1 ack, 2 reply; looks before waiting
   task automatic await(input int sel, input int n);
      logic [2:0] hit;
      for (int k = 0; k < n; k++) begin
         hit = {in_valid_o, task_ack_o, done_o};
         if (hit[sel] === 1'b1) return;
         @(negedge clock_i);
      end
      errors++;
      final_report();
   endtask
   task automatic issue(input logic [15:0] code, input logic [9:0] chan, input int rng);
      @(negedge clock_i);
      {task_valid_i, task_code_i, task_chan_i, task_range_i} = {1'b1, code, chan, 16'(rng)};
      @(negedge clock_i);
      task_valid_i = 1'b0;
   endtask
   task automatic addr(input logic [9:0] chan, input logic [15:0] a);
      @(negedge clock_i);
      {addr_load_i, addr_chan_i, addr_value_i} = {1'b1, chan, a};
      @(negedge clock_i);
      addr_load_i = 1'b0;
   endtask
   // range as it stood when the control word was taken
   task automatic ctrl(input logic [15:0] w, output logic [15:0] r);
      @(negedge clock_i);
      {ctrl_valid_i, ctrl_word_i} = {1'b1, w};
      @(negedge clock_i);
      ctrl_valid_i = 1'b0;
      r = range_o;
   endtask
   task automatic irq(input logic [5:0] l);
      @(negedge clock_i);
      {irq_level_load_i, irq_level_i} = {1'b1, l};
      @(negedge clock_i);
      irq_level_load_i = 1'b0;
      `CHK(irq_level_o, l)
   endtask
   task automatic rd_pair(input int fc, input int first);
      @(negedge clock_i);
      {in_valid_i, in_func_i} = {1'b1, 6'(fc)};
      @(negedge clock_i);
      in_valid_i = 1'b0;
      await(2, 6);
      `CHK(in_data_o, {sb(first), sb(first + 1)})
   endtask
   // clear held by the formatter
   task automatic t_clear();
      issue(tctc_pkg::TASK_CLEAR, 10'h004, 0);
      await(1, 4);
      repeat (8) @(negedge clock_i);
      `CHK(fmt_reset_o, 1'b1)
      `CHK(busy_o, 1'b1)
      fmt_reset_done_i = 1'b1;
      await(0, 10);
      fmt_reset_done_i = 1'b0;
      @(negedge clock_i);
      `CHK(busy_o, 1'b0)
      `CHK(status_word3_o[7:0], sb(0))
   endtask
   // five pages, the last one saturated
   task automatic t_sense();
      for (int i = 0; i < 40; i++) begin
         @(negedge clock_i);
         {sense_wr_i, sense_wr_addr_i, sense_wr_data_i} = {1'b1, 6'(i), sb(i)};
      end
      @(negedge clock_i);
      sense_wr_i = 1'b0;
      for (int p = 0; p < 5; p++) begin
         issue(tctc_pkg::TASK_SENSE, 10'h004, 0);
         await(1, 4);
         for (int x = 0; x < 10; x += 2) begin
            if (p == 0 || x == 0 || x == 8)
               rd_pair(54 + x, (p > 3 ? 30 : p * 10) + x);
         end
      end
      t_clear();
      issue(tctc_pkg::TASK_SENSE, 10'h004, 0);
      await(1, 4);
      rd_pair(8'h36, 0);
   endtask
   task automatic t_zero();
      int c0;
      c0 = mem_u.rd_cnt;
      addr(10'h004, 16'h0100);
      issue(tctc_pkg::TASK_WRAP_BA, 10'h004, 0);
      await(1, 4);
      repeat (6) @(negedge clock_i);
      `CHK(busy_o, 1'b0)
      `CHK(mem_u.rd_cnt, c0)
   endtask
   // write n words, read them back to 0200
   task automatic t_wrap(input logic [15:0] code, input int n, input logic slow);
      int c0;
      slow_i = slow;
      addr(10'h004, 16'h0100);
      c0 = mem_u.rd_cnt;
      issue(code, 10'h004, n);
      await(1, 4);
      repeat (2) @(negedge clock_i);
      issue(code, 10'h008, n);
      `CHK(task_ack_o || task_nak_o, 1'b0)
      await(0, 400);
      `CHK(mem_u.rd_cnt - c0, n)
      addr(10'h005, 16'h0200);
      issue(code, 10'h004, n);
      await(1, 4);
      await(0, 400);
      for (int i = 0; i < n; i++) begin
         `CHK(mem_u.wlog[16'h0200 + 16'(2*i)], mem_u.pat(16'h0100 + 16'(2*i)))
      end
   endtask
   task automatic t_stop();
      logic [15:0] r;
      irq(6'h05);
      addr(10'h004, 16'h0100);
      slow_i = 1'b1;
      issue(tctc_pkg::TASK_WRAP_BA, 10'h004, 8);
      await(1, 4);
      repeat (10) @(negedge clock_i);
      ctrl(tctc_pkg::CTRL_STOP, r);
      await(0, 6);
      `CHK(irq_o, 1'b1)
      `CHK(range_o, r)
   endtask
   task automatic t_init();
      logic [15:0] r;
      irq(6'h05);
      addr(10'h004, 16'h0100);
      issue(tctc_pkg::TASK_WRAP_FA, 10'h004, 16);
      await(1, 4);
      repeat (10) @(negedge clock_i);
      ctrl(tctc_pkg::CTRL_INIT, r);
      repeat (4) @(negedge clock_i);
      `CHK(busy_o, 1'b0)
      `CHK(irq_level_o, tctc_pkg::IRQ_LEVEL_RESET)
      `CHK(range_o, tctc_pkg::WORD_RESET)
   endtask
   // reset for 12 cycles, then the scenarios in turn
   initial begin
      {rst_b_i, task_valid_i, addr_load_i, ctrl_valid_i, irq_level_load_i} = '0;
      {in_valid_i, sense_wr_i, fmt_reset_done_i, slow_i, ce_i} = 5'b00001;
      {task_code_i, task_range_i, addr_value_i, ctrl_word_i} = '0;
      {task_chan_i, addr_chan_i, irq_level_i, in_func_i, sense_wr_addr_i} = '0;
      sense_wr_data_i = 8'h00;
      repeat (12) @(posedge clock_i);
      @(negedge clock_i);
      rst_b_i = 1'b1;
      repeat (2) @(negedge clock_i);
      t_sense();
      t_zero();
      t_wrap(tctc_pkg::TASK_WRAP_BA, 8, 1'b0);
      t_wrap(tctc_pkg::TASK_WRAP_FA, 16, 1'b1);
      t_stop();
      t_init();
      final_report();
   end
endmodule
